/* File: hsp_pkg.sv */
// shared constants, types and decoding for the host serial port block
package hsp_pkg;

  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int NUM_OUT = 7; // clock outputs gated by the enable masks
  localparam int NUM_OE = 3; // output-enable pins
  localparam int STATUS_W = 8; // monitored status bits
  localparam int REG_COUNT = 6; // registers reached through the port
  localparam int SYNC_STAGES = 2;

  // --------------------------------------------------------------
  // register map reached over i2c or spi
  // --------------------------------------------------------------
  localparam logic [6:0] REG_STATUS = 7'h00; // live status, read only
  localparam logic [6:0] REG_STICKY = 7'h01; // change flags, write one to clear
  localparam logic [6:0] REG_OE0_MASK = 7'h02;
  localparam logic [6:0] REG_OE1_MASK = 7'h03;
  localparam logic [6:0] REG_OE2_MASK = 7'h04;
  localparam logic [6:0] REG_SPI_CFG = 7'h05;

  // --------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------
  localparam int SPI_READ_BIT = 7; // command byte: 1 read, 0 write
  localparam int CFG_THREE_WIRE_BIT = 0; // spi config: 1 selects 3-wire
  localparam logic [7:0] OE0_MASK_RST = 8'h7f; // every output
  localparam logic [7:0] OEX_MASK_RST = 8'h00; // no output
  localparam logic [7:0] SPI_CFG_RST = 8'h00; // 4-wire
  localparam logic [4:0] I2C_ADDR_HI_RST = 5'h1a; // upper address bits
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef struct packed {
    logic out;
    logic oeN; // low while the pad is driven
  } hsp_pad_s;

  typedef struct packed {
    logic toggle; // flips once per spi write
    logic [6:0] addr;
    logic [7:0] data;
  } hsp_wr_s;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ADDR_ACK = 3'b010,
    I2C_WRITE = 3'b011,
    I2C_WR_ACK = 3'b100,
    I2C_READ = 3'b101,
    I2C_RD_ACK = 3'b110
  } hsp_i2c_e;

  // pick one register byte from the flattened image, zero when unmapped
  function automatic logic [7:0] hspPick(input logic [REG_COUNT*8-1:0] img,
                                         input logic [6:0] addr);
    logic [7:0] val;
    val = 8'h00;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (addr == 7'(i)) begin
        val = img[i*8 +: 8];
      end
    end
    return val;
  endfunction

endpackage

/* File: hsp_spi_link.sv */
// spi target engine running on the host serial clock
`timescale 1ns/1ps
`default_nettype none
module hsp_spi_link
  import hsp_pkg::*;
(
  input wire logic serialClock,
  input wire logic linkRst,
  input wire logic keepRstN,
  input wire logic threeWire,
  input wire logic sdiIn,
  input wire logic [REG_COUNT*8-1:0] regImage,
  output hsp_pad_s sdioPad,
  output hsp_pad_s sdoPad,
  output hsp_wr_s wrReq
);

  // --------------------------------------------------------------
  // frame shifting
  // --------------------------------------------------------------
  logic [4:0] bitCnt;
  logic [7:0] cmd;
  logic [6:0] dataShift;
  logic readPhase;
  logic [7:0] rdByte;
  logic drvBit;
  logic drvOn;

  // command then data, sampled on the rising edge; idle select clears it
  always_ff @(posedge serialClock or posedge linkRst) begin
    if (linkRst) begin
      bitCnt <= 5'h00; // R15
      cmd <= 8'h00;
      dataShift <= 7'h00;
    end else begin
      if (bitCnt != SPI_FRAME_BITS) begin
        bitCnt <= bitCnt + 5'h01; // R5
      end
      if (bitCnt < 5'(BYTE_BITS)) begin
        cmd <= {cmd[6:0], sdiIn};
      end else begin
        dataShift <= {dataShift[5:0], sdiIn};
      end
    end
  end

  // write handed to the core clock as a toggle with held address and data
  always_ff @(posedge serialClock or negedge keepRstN) begin
    if (!keepRstN) begin
      wrReq <= '0;
    end else if (bitCnt == SPI_FRAME_BITS - 5'h01 && !cmd[SPI_READ_BIT]) begin
      wrReq.toggle <= ~wrReq.toggle;
      wrReq.addr <= cmd[6:0];
      wrReq.data <= {dataShift, sdiIn};
    end
  end

  // --------------------------------------------------------------
  // read data, launched on the falling edge
  // --------------------------------------------------------------
  assign readPhase = cmd[SPI_READ_BIT] && bitCnt >= 5'(BYTE_BITS)
                     && bitCnt < SPI_FRAME_BITS;
  assign rdByte = hspPick(regImage, cmd[6:0]);

  always_ff @(negedge serialClock or posedge linkRst) begin
    if (linkRst) begin
      drvOn <= 1'b0; // R15
      drvBit <= 1'b1;
    end else begin
      drvOn <= readPhase;
      drvBit <= rdByte[3'h7 - bitCnt[2:0]];
    end
  end

  // data out on the shared data pin in 3-wire, on the second pin in 4-wire
  assign sdioPad.out = drvBit; // R3
  assign sdioPad.oeN = !(drvOn && threeWire); // R3
  assign sdoPad.out = drvBit; // R4
  assign sdoPad.oeN = !(drvOn && !threeWire); // R4

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  sequence wordDone;
    bitCnt == SPI_FRAME_BITS - 5'h01 && !cmd[SPI_READ_BIT];
  endsequence

  spi_write_toggle_a: assert property ( // R5
    @(negedge serialClock) disable iff (linkRst || !keepRstN)
    wordDone |=> wrReq.toggle != $past(wrReq.toggle))
    else $error("spi write did not toggle the request");

  spi_pin_choice_a: assert property ( // R3
    @(posedge serialClock) disable iff (linkRst || !keepRstN)
    !(!sdioPad.oeN && !sdoPad.oeN))
    else $error("spi drives both data pins at once");

endmodule
`default_nettype wire

/* File: hsp_port.sv */
// host serial port with mode strap, reset, interrupt and output enables
//
// Behaviour
// [R1] interface_select high gives an i2c target, low gives an spi target.
// [R2] interface_select reads high when undriven, so i2c is the default.
// [R3] data pin is two-way for i2c and 3-wire spi, input only in 4-wire.
// [R4] second pin is i2c address bit 1, or read data out in 4-wire spi.
// [R5] host supplies the serial clock; every port transfer is timed by it.
// [R6] select pin is i2c address bit 0, or active-low spi chip select.
// [R7] select pin reads high when undriven: spi idle, i2c address bit one.
// [R8] irq_n goes low whenever monitored status has changed.
// [R9] reset pin low resets all logic and loads register defaults.
// [R10] clock outputs stay disabled while reset is in effect.
// [R11] reset pin reads high when undriven, so the device runs.
// [R12] each output-enable pin controls the outputs its register mask selects.
// [R13] after reset enable pin 0 gates every output, the others none.
// [R14] i2c address low bits come from pins; only a match is acknowledged.
// [R15] 4-wire spi with select high leaves data out undriven, clock ignored.
`timescale 1ns/1ps
`default_nettype none
module hsp_port
  import hsp_pkg::*;
#(
  parameter logic [4:0] I2C_ADDR_HI = I2C_ADDR_HI_RST
)(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic serialClock,
  input wire logic interface_select,
  input wire logic serial_data_io_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe_n,
  input wire logic addr1_or_data_out_in,
  output logic addr1_or_data_out_out,
  output logic addr1_or_data_out_oe_n,
  input wire logic addr0_or_select_n,
  input wire logic device_reset_n,
  input wire logic out_enable0_n,
  input wire logic out_enable1_n,
  input wire logic out_enable2_n,
  input wire logic [STATUS_W-1:0] statusIn,
  output logic irq_n,
  output logic [NUM_OUT-1:0] clkOutEnable
);

  // --------------------------------------------------------------
  // reset release and pin synchronisers
  // --------------------------------------------------------------
  logic [SYNC_STAGES-1:0] rstPipe;
  logic coreRstN;
  logic logicRstN;
  logic [6:0] pinMeta;
  logic [6:0] pinSync;
  logic devPinSync;
  logic i2cMode;
  logic a0Sync;
  logic a1Sync;
  logic sclSync;
  logic sdaSync;
  logic [NUM_OE-1:0] oeSync;

  // core reset: asserted at once, released through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= '0;
    end else begin
      rstPipe <= {rstPipe[SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign coreRstN = rstPipe[SYNC_STAGES-1];

  // pins pass two flops; pulled-up pins start high
  always_ff @(posedge core_clk or negedge coreRstN) begin
    if (!coreRstN) begin
      pinMeta <= 7'h0f; // R2 R7 R11
      pinSync <= 7'h0f; // R2 R7 R11
    end else begin
      pinMeta <= {out_enable2_n, out_enable1_n, out_enable0_n, device_reset_n,
                  addr0_or_select_n, interface_select, addr1_or_data_out_in};
      pinSync <= pinMeta;
    end
  end
  assign a1Sync = pinSync[0];
  assign i2cMode = pinSync[1]; // R1
  assign a0Sync = pinSync[2]; // R6
  assign devPinSync = pinSync[3];
  assign oeSync = pinSync[6:4];

  // serial clock and data sampled for the i2c engine
  logic [1:0] busMeta;
  logic [1:0] busSync;
  logic [1:0] busLast;
  always_ff @(posedge core_clk or negedge coreRstN) begin
    if (!coreRstN) begin
      busMeta <= 2'h3;
      busSync <= 2'h3;
      busLast <= 2'h3;
    end else begin
      busMeta <= {serialClock, serial_data_io_in}; // R5
      busSync <= busMeta;
      busLast <= busSync;
    end
  end
  assign sclSync = busSync[1];
  assign sdaSync = busSync[0];

  // device reset pin folds into the logic reset
  always_ff @(posedge core_clk or negedge coreRstN) begin
    if (!coreRstN) begin
      logicRstN <= 1'b0;
    end else begin
      logicRstN <= devPinSync; // R9
    end
  end

  // --------------------------------------------------------------
  // registers and their write port
  // --------------------------------------------------------------
  logic [7:0] oeMask [NUM_OE];
  logic [7:0] spiCfg;
  logic [STATUS_W-1:0] sticky;
  logic [STATUS_W-1:0] statusLast;
  logic wrStb;
  logic [6:0] wrAddr;
  logic [7:0] wrData;
  logic i2cWrStb;
  logic [6:0] i2cWrAddr;
  logic [7:0] i2cWrData;
  hsp_wr_s spiWr;
  logic [2:0] togPipe;
  logic spiWrStb;
  logic [REG_COUNT*8-1:0] liveImage;
  logic [REG_COUNT*8-1:0] regImage;

  // spi write toggle crosses in; address and data are held meanwhile
  always_ff @(posedge core_clk or negedge logicRstN) begin
    if (!logicRstN) begin
      togPipe <= 3'h0;
    end else begin
      togPipe <= {togPipe[1:0], spiWr.toggle};
    end
  end
  assign spiWrStb = togPipe[2] ^ togPipe[1];

  // one write port for both modes
  assign wrStb = i2cMode ? i2cWrStb : spiWrStb; // R1
  assign wrAddr = i2cMode ? i2cWrAddr : spiWr.addr;
  assign wrData = i2cMode ? i2cWrData : spiWr.data;

  // mask and config registers, defaults loaded by either reset
  always_ff @(posedge core_clk or negedge logicRstN) begin
    if (!logicRstN) begin
      oeMask[0] <= OE0_MASK_RST; // R9 R13
      oeMask[1] <= OEX_MASK_RST; // R13
      oeMask[2] <= OEX_MASK_RST; // R13
      spiCfg <= SPI_CFG_RST;
    end else if (wrStb) begin
      case (wrAddr)
        REG_OE0_MASK: oeMask[0] <= wrData; // R12
        REG_OE1_MASK: oeMask[1] <= wrData; // R12
        REG_OE2_MASK: oeMask[2] <= wrData; // R12
        REG_SPI_CFG: spiCfg <= wrData;
        default: ;
      endcase
    end
  end

  // status change flags; a new change wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge logicRstN) begin
    if (!logicRstN) begin
      statusLast <= '0;
      sticky <= '0;
    end else begin
      statusLast <= statusIn;
      sticky <= (sticky & ~((wrStb && wrAddr == REG_STICKY) ? wrData : 8'h00))
                | (statusIn ^ statusLast); // R8
    end
  end

  // interrupt pin low while any change flag stands
  always_ff @(posedge core_clk or negedge logicRstN) begin
    if (!logicRstN) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|sticky; // R8
    end
  end

  assign liveImage = {spiCfg, oeMask[2], oeMask[1], oeMask[0], sticky, statusIn};

  // read image for the spi clock, frozen while a frame is open
  always_ff @(posedge core_clk or negedge logicRstN) begin
    if (!logicRstN) begin
      regImage <= '0;
    end else if (i2cMode || a0Sync) begin
      regImage <= liveImage;
    end
  end

  // --------------------------------------------------------------
  // clock output enables
  // --------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < NUM_OUT; k++) begin : gOut
      // an output runs unless a pin whose mask holds it is high
      always_ff @(posedge core_clk or negedge logicRstN) begin
        if (!logicRstN) begin
          clkOutEnable[k] <= 1'b0; // R10
        end else begin
          clkOutEnable[k] <= !((oeMask[0][k] && oeSync[0]) ||
                               (oeMask[1][k] && oeSync[1]) ||
                               (oeMask[2][k] && oeSync[2])); // R12
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // i2c target
  // --------------------------------------------------------------
  hsp_i2c_e i2cState;
  logic [3:0] bitCnt;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic [6:0] regPtr;
  logic ptrLoaded;
  logic sdaLow;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [6:0] myAddr;
  logic [7:0] ptrByte;

  assign sclRise = sclSync && !busLast[1];
  assign sclFall = !sclSync && busLast[1];
  assign startSeen = sclSync && busLast[1] && !sdaSync && busLast[0];
  assign stopSeen = sclSync && busLast[1] && sdaSync && !busLast[0];
  assign myAddr = {I2C_ADDR_HI, a1Sync, a0Sync}; // R4 R6 R14
  // byte at the register pointer, first bit of a read goes out at once
  assign ptrByte = hspPick(liveImage, regPtr);

  // byte engine stepped by the sampled host clock
  always_ff @(posedge core_clk or negedge logicRstN) begin
    if (!logicRstN) begin
      i2cState <= I2C_IDLE;
      bitCnt <= 4'h0;
      rxShift <= 8'h00;
      txShift <= 8'h00;
      regPtr <= 7'h00;
      ptrLoaded <= 1'b0;
      sdaLow <= 1'b0;
      i2cWrStb <= 1'b0;
      i2cWrAddr <= 7'h00;
      i2cWrData <= 8'h00;
    end else begin
      i2cWrStb <= 1'b0;
      if (!i2cMode) begin
        i2cState <= I2C_IDLE; // R1
        sdaLow <= 1'b0;
      end else if (startSeen) begin
        i2cState <= I2C_ADDR;
        bitCnt <= 4'h0;
        sdaLow <= 1'b0;
      end else if (stopSeen) begin
        i2cState <= I2C_IDLE;
        sdaLow <= 1'b0;
      end else if (sclRise) begin
        case (i2cState)
          I2C_ADDR, I2C_WRITE: begin
            rxShift <= {rxShift[6:0], sdaSync};
            bitCnt <= bitCnt + 4'h1;
          end
          I2C_READ: bitCnt <= bitCnt + 4'h1;
          I2C_RD_ACK: rxShift[0] <= sdaSync; // host acknowledge
          default: ;
        endcase
      end else if (sclFall) begin
        case (i2cState)
          I2C_ADDR: begin
            if (bitCnt == BYTE_BITS) begin
              if (rxShift[7:1] == myAddr) begin
                i2cState <= I2C_ADDR_ACK; // R14
                sdaLow <= 1'b1;
              end else begin
                i2cState <= I2C_IDLE; // R14
              end
            end
          end
          I2C_ADDR_ACK: begin
            bitCnt <= 4'h0;
            ptrLoaded <= 1'b0;
            if (rxShift[0]) begin
              i2cState <= I2C_READ;
              txShift <= ptrByte;
              sdaLow <= !ptrByte[7];
            end else begin
              i2cState <= I2C_WRITE;
              sdaLow <= 1'b0;
            end
          end
          I2C_WRITE: begin
            if (bitCnt == BYTE_BITS) begin
              i2cState <= I2C_WR_ACK;
              sdaLow <= 1'b1;
              if (!ptrLoaded) begin
                regPtr <= rxShift[6:0];
                ptrLoaded <= 1'b1;
              end else begin
                i2cWrStb <= 1'b1;
                i2cWrAddr <= regPtr;
                i2cWrData <= rxShift;
                regPtr <= regPtr + 7'h01;
              end
            end
          end
          I2C_WR_ACK: begin
            i2cState <= I2C_WRITE;
            bitCnt <= 4'h0;
            sdaLow <= 1'b0;
          end
          I2C_READ: begin
            if (bitCnt == BYTE_BITS) begin
              i2cState <= I2C_RD_ACK;
              sdaLow <= 1'b0;
              regPtr <= regPtr + 7'h01;
            end else begin
              txShift <= {txShift[6:0], 1'b0};
              sdaLow <= !txShift[6];
            end
          end
          I2C_RD_ACK: begin
            bitCnt <= 4'h0;
            if (rxShift[0]) begin
              i2cState <= I2C_IDLE; // no acknowledge ends the read
              sdaLow <= 1'b0;
            end else begin
              i2cState <= I2C_READ;
              txShift <= ptrByte;
              sdaLow <= !ptrByte[7];
            end
          end
          default: i2cState <= I2C_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // spi target on the host clock and pad drive
  // --------------------------------------------------------------
  hsp_pad_s sdioPad;
  hsp_pad_s sdoPad;
  logic spiLinkRst;

  // select high, i2c mode or reset keeps the spi engine cleared
  assign spiLinkRst = i2cMode || addr0_or_select_n || !logicRstN; // R6 R15

  hsp_spi_link uSpi (
    .serialClock(serialClock),
    .linkRst(spiLinkRst),
    .keepRstN(logicRstN),
    .threeWire(spiCfg[CFG_THREE_WIRE_BIT]),
    .sdiIn(serial_data_io_in),
    .regImage(regImage),
    .sdioPad(sdioPad),
    .sdoPad(sdoPad),
    .wrReq(spiWr)
  );

  // i2c only pulls the data line low; spi uses its own flops
  assign serial_data_io_out = i2cMode ? 1'b0 : sdioPad.out; // R3
  assign serial_data_io_oe_n = i2cMode ? !sdaLow : sdioPad.oeN; // R3
  assign addr1_or_data_out_out = sdoPad.out; // R4
  assign addr1_or_data_out_oe_n = i2cMode ? 1'b1 : sdoPad.oeN; // R4 R15

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  sequence addrDone;
    i2cMode && i2cState == I2C_ADDR && sclFall && bitCnt == BYTE_BITS;
  endsequence

  irq_on_change_a: assert property ( // R8
    @(posedge core_clk) disable iff (!logicRstN)
    (statusIn != statusLast) |=> ##1 !irq_n)
    else $error("status change did not pull irq low");

  irq_released_a: assert property ( // R8
    @(posedge core_clk) disable iff (!logicRstN)
    (sticky == '0) |=> irq_n)
    else $error("irq low with no change flag");

  clk_off_reset_a: assert property ( // R10
    @(posedge core_clk) disable iff (!coreRstN)
    !devPinSync |=> ##1 (clkOutEnable == '0))
    else $error("clock output enabled during reset");

  mask_default_a: assert property ( // R13
    @(posedge core_clk) disable iff (!coreRstN)
    $rose(logicRstN) |-> (oeMask[0] == OE0_MASK_RST && oeMask[1] == OEX_MASK_RST
                          && oeMask[2] == OEX_MASK_RST))
    else $error("enable masks not at default after reset");

  oe_gate_a: assert property ( // R12
    @(posedge core_clk) disable iff (!logicRstN)
    (oeSync[0] && oeMask[0][0]) |=> !clkOutEnable[0])
    else $error("masked enable pin did not stop output 0");

  addr_match_a: assert property ( // R14
    @(posedge core_clk) disable iff (!logicRstN)
    addrDone ##0 (rxShift[7:1] == myAddr) |=> sdaLow ##1 !serial_data_io_oe_n)
    else $error("matching i2c address not acknowledged");

  addr_miss_a: assert property ( // R14
    @(posedge core_clk) disable iff (!logicRstN)
    addrDone ##0 (rxShift[7:1] != myAddr) |=> (i2cState == I2C_IDLE) [*2])
    else $error("foreign i2c address not ignored");

  spi_quiet_a: assert property ( // R15
    @(posedge core_clk) disable iff (!logicRstN)
    (!i2cMode && a0Sync) |-> addr1_or_data_out_oe_n)
    else $error("data out driven with select high");

  i2c_no_a1_a: assert property ( // R4
    @(posedge core_clk) disable iff (!logicRstN)
    i2cMode |-> addr1_or_data_out_oe_n && serial_data_io_out == 1'b0)
    else $error("i2c mode drives the address pin or data high");

endmodule
`default_nettype wire

/* File: hsp_spi_host.sv */
// spi host model that drives the serial port frames
`timescale 1ns/1ps
`default_nettype none
module hsp_spi_host (
  output logic serialClock,
  output logic csN,
  output logic sdioLine,
  input wire logic devOut,
  input wire logic devOeN,
  input wire logic sdoOut,
  input wire logic sdoOeN
);
  logic hostEn;
  logic hostBit;
  // shared data wire, a released host line shows the inverse bit
  assign sdioLine = !devOeN ? devOut : (hostEn ? hostBit : ~hostBit);
  initial begin
    serialClock = 1'b0; // clock stands still between frames
    csN = 1'b1;
    hostEn = 1'b1;
    hostBit = 1'b0;
  end
  // one 16 bit frame msb first, result is {pin driven, read byte}
  task automatic frame(input logic [15:0] f, input logic useCs, input logic three,
                       output logic [8:0] res);
    res = 9'h000;
    csN = !useCs; // select low frames the transfer
    #7.5;
    for (int i = 15; i >= 0; i--) begin
      hostEn = !(three && f[15] && i < 8);
      hostBit = f[i];
      #7.5 serialClock = 1'b1; // host supplies every edge
      if (i < 8) begin
        res = {res[8] | !devOeN | !sdoOeN, res[6:0], three ? sdioLine : (sdoOeN | sdoOut)};
      end
      #7.5 serialClock = 1'b0;
    end
    #7.5 csN = 1'b1;
    hostEn = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: tb_hsp_port.sv */
// self-checking bench of the host serial port
`timescale 1ns/1ps
`default_nettype none
module tb_hsp_port;
  import hsp_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ifSel = 1'b0;
  logic devRstN = 1'b1;
  logic [2:0] oeN = 3'b000;
  logic [STATUS_W-1:0] status = 8'h00;
  wire sclk, csN, sdio, dOut, dOeN, aOut, aOeN, irqN;
  wire [NUM_OUT-1:0] clkEn;
  logic [8:0] expQ[$];
  logic [8:0] seen;
  logic [6:0] en;
  logic [31:0] rnd = 32'h929cf8f7;
  int failures = 0;
  int checked = 0;
  event obs;

  // core clock, 50 ns period
  always #25 core_clk = ~core_clk;

  hsp_spi_host host (.serialClock(sclk), .csN(csN), .sdioLine(sdio), .devOut(dOut),
    .devOeN(dOeN), .sdoOut(aOut), .sdoOeN(aOeN));
  hsp_port DUT (.core_clk(core_clk), .rst_b(rst_b), .serialClock(sclk),
    .interface_select(ifSel), .serial_data_io_in(sdio), .serial_data_io_out(dOut),
    .serial_data_io_oe_n(dOeN), .addr1_or_data_out_in(aOeN ? 1'b0 : aOut),
    .addr1_or_data_out_out(aOut), .addr1_or_data_out_oe_n(aOeN),
    .addr0_or_select_n(csN), .device_reset_n(devRstN), .out_enable0_n(oeN[0]),
    .out_enable1_n(oeN[1]), .out_enable2_n(oeN[2]), .statusIn(status), .irq_n(irqN),
    .clkOutEnable(clkEn));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  // compare each observed result with the oldest note
  always @(obs) begin
    check(seen, expQ.pop_front());
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic xfer(input logic [15:0] f, input logic cs, input logic three,
                      input logic [8:0] exp);
    expQ.push_back(exp);
    host.frame(f, cs, three, seen);
    ->obs;
    step(8);
  endtask

  task automatic pin(input logic [8:0] got, input logic [8:0] exp);
    expQ.push_back(exp);
    seen = got;
    ->obs;
    step(1);
  endtask

  // i2c address byte with write bit, result is the data line at the ninth clock
  task automatic i2cAddr(input logic [6:0] a, input logic [8:0] exp);
    logic [8:0] f;
    f = {a, 1'b0, 1'b1};
    expQ.push_back(exp);
    host.hostEn = 1'b1;
    host.hostBit = 1'b1;
    host.serialClock = 1'b1;
    step(5);
    host.hostBit = 1'b0; // start
    step(5);
    for (int i = 8; i >= 0; i--) begin
      host.serialClock = 1'b0;
      step(2);
      host.hostBit = f[i];
      step(3);
      host.serialClock = 1'b1;
      step(5);
      seen = {8'h00, sdio};
    end
    host.serialClock = 1'b0;
    step(2);
    host.hostBit = 1'b0;
    step(3);
    host.serialClock = 1'b1;
    step(5);
    host.hostBit = 1'b1; // stop
    step(5);
    host.serialClock = 1'b0;
    step(5);
    ->obs;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic three);
    xfer({1'b0, a, d}, 1'b1, three, {1'b0, three ? d : 8'hff});
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] d);
    xfer({1'b1, a, 8'h00}, 1'b1, 1'b0, {1'b1, d});
  endtask

  task automatic results();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence with a watchdog beside it
  initial begin
    fork
      begin
        #300000;
        failures++;
        results();
      end
    join_none
    step(2);
    pin({2'b00, clkEn}, 9'h000);
    step(5);
    rst_b = 1'b1;
    step(8);
    pin({2'b00, clkEn}, 9'h07f);
    pin({8'h00, irqN}, 9'h001);
    rd(REG_OE0_MASK, OE0_MASK_RST);
    rd(REG_OE1_MASK, OEX_MASK_RST);
    rd(REG_OE2_MASK, OEX_MASK_RST);
    rd(REG_SPI_CFG, SPI_CFG_RST);
    xfer(16'hffff, 1'b1, 1'b0, 9'h100);
    oeN = 3'b110;
    step(4);
    pin({2'b00, clkEn}, 9'h07f);
    // random masks and enable pins
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(REG_OE1_MASK, {1'b0, rnd[6:0]}, 1'b0);
      wr(REG_OE2_MASK, {1'b0, rnd[14:8]}, 1'b0);
      oeN = rnd[18:16];
      step(4);
      en = ~((oeN[0] ? 7'h7f : 7'h00) | (oeN[1] ? rnd[6:0] : 7'h00) | (oeN[2] ? rnd[14:8] : 7'h00));
      pin({2'b00, clkEn}, {2'b00, en});
      rd(REG_OE1_MASK, {1'b0, rnd[6:0]});
    end
    status = 8'h3c;
    step(4);
    pin({8'h00, irqN}, 9'h000);
    rd(REG_STATUS, 8'h3c);
    wr(REG_STICKY, 8'hff, 1'b0);
    pin({8'h00, irqN}, 9'h001);
    xfer({1'b0, REG_OE1_MASK, 8'h55}, 1'b0, 1'b0, 9'h0ff);
    rd(REG_OE1_MASK, {1'b0, rnd[6:0]});
    wr(REG_SPI_CFG, 8'h01, 1'b0);
    xfer({1'b1, REG_OE0_MASK, 8'h00}, 1'b1, 1'b1, {1'b1, OE0_MASK_RST});
    wr(REG_SPI_CFG, 8'h00, 1'b1);
    ifSel = 1'b1;
    step(4);
    xfer(16'hffff, 1'b1, 1'b0, 9'h0ff);
    i2cAddr({I2C_ADDR_HI_RST, 2'b01}, 9'h000);
    i2cAddr({I2C_ADDR_HI_RST, 2'b11}, 9'h001);
    ifSel = 1'b0;
    oeN = 3'b000;
    devRstN = 1'b0;
    step(5);
    pin({2'b00, clkEn}, 9'h000);
    devRstN = 1'b1;
    step(8);
    rd(REG_OE1_MASK, OEX_MASK_RST);
    results();
  end
endmodule
`default_nettype wire
